// ### hdl/bdr_bus_if.sv
// multiplexed host bus between host end and board glue end
`timescale 1ns/1ps
interface bdr_bus_if;
  logic ale;
  logic rd_n;
  logic wr_n;
  logic [7:0] addr_hi;
  logic [7:0] ad_host;
  logic ad_host_oe;
  logic [7:0] ad_dev;
  logic ad_dev_oe;
  logic [7:0] ad;
  // pulled high when nobody drives
  assign ad = ad_host_oe ? ad_host : (ad_dev_oe ? ad_dev : 8'hff);
  modport host (
    output ale, rd_n, wr_n, addr_hi, ad_host, ad_host_oe,
    input ad
  );
  modport dev (
    input ale, rd_n, wr_n, addr_hi, ad,
    output ad_dev, ad_dev_oe
  );
endinterface

// ### hdl/bdr_glue_end.sv
// board glue end: decode, boot remap, clock divide, pio and controller regs
//
// Decided for this implementation: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ps
module bdr_glue_end (
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  bdr_bus_if.dev bus,
  input wire logic key_a_n_in,
  input wire logic key_b_n_in,
  input wire logic osc_6mhz_in,
  output logic monitor_low_select_n_out,
  output logic monitor_high_select_n_out,
  output logic pio_select_n_out,
  output logic peripheral_ctrl_select_n_out,
  output logic user_low_select_n_out,
  output logic [11:0] monitor_byte_addr_out,
  output logic io_memory_select_out,
  output logic [2:0] pio_op_out,
  output logic breakpoint_mem_write_n_out,
  output logic boot_remap_latch_n_out,
  output logic board_reset_out,
  output logic board_reset_n_out,
  output logic ctrl_clock_6mhz_out,
  output logic ctrl_clock_6mhz_n_out,
  output logic divided_system_clock_out,
  output logic serial_rate_clock_out,
  input wire logic [7:0] port_a_in,
  output logic [7:0] port_a_out,
  output logic [7:0] port_a_oe_out,
  input wire logic [7:0] port_b_in,
  output logic [7:0] port_b_out,
  output logic [7:0] port_b_oe_out,
  input wire logic [5:0] port_c_in,
  output logic [5:0] port_c_out,
  output logic [5:0] port_c_oe_out,
  output logic [7:0] ctrl_in_data_out,
  output logic ctrl_in_is_cmd_out,
  output logic ctrl_in_full_out,
  input wire logic ctrl_in_taken_in,
  input wire logic [7:0] ctrl_out_data_in,
  input wire logic ctrl_out_load_in,
  output logic ctrl_out_full_out
);
  typedef struct packed {
    logic ale;
    logic rd_n;
    logic wr_n;
    logic [15:0] addr;
    logic [4:0] sel_n;
    logic bpw_n;
    logic remap_n;
    logic [7:0] rdata;
    logic both;
    logic [7:0] rcnt;
    logic rst;
    logic osc;
    logic [1:0] div;
    logic divided_system_clock;
    logic tick;
    logic [3:0] cmd;
    logic [7:0] pa;
    logic [7:0] pb;
    logic [5:0] pc;
    logic [13:0] tdiv;
    logic [13:0] tcnt;
    logic baud;
    logic [7:0] ibuf;
    logic [7:0] obuf;
    logic ibf;
    logic obf;
    logic f1;
  } bdr_glue_t;
  bdr_glue_t q, d;
  logic [7:0] pio_ram [256];
  logic [2:0] pins;
  logic [3:0] nib;
  logic wr_fall, rd_rise, both, sel_pio, sel_ctrl;
  bdr_pin_sync #(.WIDTH(3), .INIT(3'b011)) u_sync (
    .core_clk_in(core_clk_in),
    .reset_n_in(reset_n_in),
    .pin_in({osc_6mhz_in, key_b_n_in, key_a_n_in}),
    .level_out(pins)
  );
  assign nib = q.addr[15:12];
  assign sel_ctrl = !q.sel_n[3];
  assign sel_pio = !q.sel_n[2];
  // strobes count only with ale low
  assign wr_fall = q.wr_n && !bus.wr_n && !bus.ale;
  assign rd_rise = !q.rd_n && bus.rd_n && !q.ale;
  assign both = !pins[0] && !pins[1];
  always_comb begin
    d = q;
    d.ale = bus.ale;
    d.rd_n = bus.rd_n;
    d.wr_n = bus.wr_n;
    if (q.ale && !bus.ale) begin
      d.addr = {bus.addr_hi, bus.ad};
    end
    // selects: {user0, ctrl, pio, mon_hi, mon_lo}, one-hot or none
    d.sel_n = 5'h1f;
    case (d.addr[15:12])
      bdr_pkg::NIB_MON_LO: d.sel_n[0] = 1'b0;
      bdr_pkg::NIB_MON_HI: d.sel_n[1] = 1'b0;
      bdr_pkg::NIB_PIO: d.sel_n[2] = 1'b0;
      bdr_pkg::NIB_CTRL: d.sel_n[3] = 1'b0;
      default: begin
        if (d.addr[15:13] == bdr_pkg::USR0_TOP3) begin
          if (!q.remap_n) begin
            d.sel_n[0] = 1'b0;
          end else begin
            d.sel_n[4] = 1'b0;
          end
        end
      end
    endcase
    d.bpw_n = !(!bus.wr_n && !bus.ale
      && (nib == bdr_pkg::NIB_BP_LO || nib == bdr_pkg::NIB_BP_HI));
    // one pulse per power-on or per two-key press
    d.both = both;
    if (both && !q.both) begin
      d.rcnt = 8'(bdr_pkg::RST_CYC);
    end else if (q.rcnt != 8'h00) begin
      d.rcnt = q.rcnt - 8'h01;
    end
    d.rst = (q.rcnt != 8'h00);
    if (q.rst) begin
      d.remap_n = 1'b0;
    end else if (!q.bpw_n) begin
      d.remap_n = 1'b1;
    end
    // divide by three on oscillator rising edges
    d.osc = pins[2];
    d.tick = 1'b0;
    if (pins[2] && !q.osc) begin
      d.div = (q.div == 2'(bdr_pkg::DIV_RATIO - 1)) ? 2'h0 : q.div + 2'h1;
      d.tick = (q.div == 2'h0);
    end
    d.divided_system_clock = (q.div == 2'h0);
    if (q.tick) begin
      if (q.tcnt == 14'h0000) begin
        d.tcnt = q.tdiv;
        d.baud = !q.baud;
      end else begin
        d.tcnt = q.tcnt - 14'h0001;
      end
    end
    if (wr_fall && sel_pio && q.addr[11]) begin
      case (q.addr[2:0])
        bdr_pkg::PIO_CMD: d.cmd = bus.ad[3:0];
        bdr_pkg::PIO_PA: d.pa = bus.ad;
        bdr_pkg::PIO_PB: d.pb = bus.ad;
        bdr_pkg::PIO_PC: d.pc = bus.ad[5:0];
        bdr_pkg::PIO_TLO: d.tdiv[7:0] = bus.ad;
        bdr_pkg::PIO_THI: d.tdiv[13:8] = bus.ad[5:0];
        default: d.cmd = q.cmd;
      endcase
    end
    // controller: new byte sets the full flag over a same-cycle take
    if (ctrl_in_taken_in) begin
      d.ibf = 1'b0;
    end
    if (wr_fall && sel_ctrl) begin
      d.ibuf = bus.ad;
      d.f1 = !q.addr[0];
      d.ibf = 1'b1;
    end
    if (rd_rise && sel_ctrl && q.addr[0]) begin
      d.obf = 1'b0;
    end
    if (ctrl_out_load_in) begin
      d.obuf = ctrl_out_data_in;
      d.obf = 1'b1;
    end
    d.rdata = 8'h00;
    if (sel_ctrl) begin
      d.rdata = q.addr[0] ? q.obuf : {4'h0, q.f1, 1'b0, q.ibf, q.obf};
    end else if (sel_pio && !q.addr[11]) begin
      d.rdata = pio_ram[q.addr[7:0]];
    end else if (sel_pio) begin
      case (q.addr[2:0])
        bdr_pkg::PIO_CMD: d.rdata = {7'h00, q.baud};
        bdr_pkg::PIO_PA: d.rdata = q.cmd[bdr_pkg::CMD_PA_OUT] ? q.pa : port_a_in;
        bdr_pkg::PIO_PB: d.rdata = q.cmd[bdr_pkg::CMD_PB_OUT] ? q.pb : port_b_in;
        bdr_pkg::PIO_PC: begin
          if (q.cmd[bdr_pkg::CMD_PC_STAT]) begin
            d.rdata = {6'h00, q.cmd[bdr_pkg::CMD_PB_OUT],
              q.cmd[bdr_pkg::CMD_PA_OUT]};
          end else begin
            d.rdata = {2'h0, q.cmd[bdr_pkg::CMD_PC_OUT] ? q.pc : port_c_in};
          end
        end
        bdr_pkg::PIO_TLO: d.rdata = q.tdiv[7:0];
        bdr_pkg::PIO_THI: d.rdata = {2'h0, q.tdiv[13:8]};
        default: d.rdata = 8'h00;
      endcase
    end
    // board reset re-inits ports, timer and controller flags
    if (q.rst) begin
      d.cmd = bdr_pkg::CMD_RST;
      d.tdiv = bdr_pkg::TDIV_RST;
      d.ibf = 1'b0;
      d.obf = 1'b0;
    end
  end
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      q <= '{ale: 1'b0, rd_n: 1'b1, wr_n: 1'b1, sel_n: 5'h1f,
        bpw_n: 1'b1, rcnt: 8'(bdr_pkg::RST_CYC), rst: 1'b1,
        cmd: bdr_pkg::CMD_RST, tdiv: bdr_pkg::TDIV_RST,
        tcnt: bdr_pkg::TDIV_RST, default: '0};
    end else begin
      q <= d;
    end
  end
  // ram is monitor-owned, no guard against user writes
  always_ff @(posedge core_clk_in) begin
    if (wr_fall && sel_pio && !q.addr[11]) begin
      pio_ram[q.addr[7:0]] <= bus.ad;
    end
  end
  assign monitor_low_select_n_out = q.sel_n[0];
  assign monitor_high_select_n_out = q.sel_n[1];
  assign pio_select_n_out = q.sel_n[2];
  assign peripheral_ctrl_select_n_out = q.sel_n[3];
  assign user_low_select_n_out = q.sel_n[4];
  assign monitor_byte_addr_out = q.addr[11:0];
  assign io_memory_select_out = q.addr[11];
  assign pio_op_out = q.addr[2:0];
  assign breakpoint_mem_write_n_out = q.bpw_n;
  assign boot_remap_latch_n_out = q.remap_n;
  assign board_reset_out = q.rst;
  assign board_reset_n_out = !q.rst;
  assign ctrl_clock_6mhz_out = q.osc;
  assign ctrl_clock_6mhz_n_out = !q.osc;
  assign divided_system_clock_out = q.divided_system_clock;
  assign serial_rate_clock_out = q.baud;
  assign port_a_out = q.pa;
  assign port_a_oe_out = {8{q.cmd[bdr_pkg::CMD_PA_OUT]}};
  assign port_b_out = q.pb;
  assign port_b_oe_out = {8{q.cmd[bdr_pkg::CMD_PB_OUT]}};
  assign port_c_out = q.pc;
  assign port_c_oe_out = {6{q.cmd[bdr_pkg::CMD_PC_OUT]
    && !q.cmd[bdr_pkg::CMD_PC_STAT]}};
  assign ctrl_in_data_out = q.ibuf;
  assign ctrl_in_is_cmd_out = q.f1;
  assign ctrl_in_full_out = q.ibf;
  assign ctrl_out_full_out = q.obf;
  assign bus.ad_dev = q.rdata;
  assign bus.ad_dev_oe = !bus.ale && !bus.rd_n && (sel_pio || sel_ctrl);
endmodule

// ### hdl/bdr_host_end.sv
// host end: runs multiplexed bus cycles ordered over ahb-lite
`timescale 1ns/1ps
module bdr_host_end (
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  bdr_bus_if.host bus
);
  typedef struct packed {
    bdr_pkg::bdr_hstate_t st;
    logic [3:0] cnt;
    logic [15:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic wr;
    logic dph;
    logic dwr;
    logic [3:0] daddr;
    logic ale;
    logic rd_n;
    logic wr_n;
    logic oe;
  } bdr_host_t;
  bdr_host_t q, d;
  logic busy;
  assign busy = (q.st != bdr_pkg::HS_IDLE);
  always_comb begin
    d = q;
    d.dph = hsel && hready && htrans[1];
    if (hsel && hready && htrans[1]) begin
      d.dwr = hwrite;
      d.daddr = haddr[3:0];
    end
    case (q.st)
      bdr_pkg::HS_IDLE: begin
        if (q.dph && q.dwr && q.daddr == bdr_pkg::HR_CTRL
            && hwdata[bdr_pkg::HC_GO]) begin
          d.st = bdr_pkg::HS_ALE;
          d.wr = hwdata[bdr_pkg::HC_WRITE];
          d.cnt = 4'(bdr_pkg::ALE_CYC - 1);
          d.ale = 1'b1;
          d.oe = 1'b1;
        end
      end
      bdr_pkg::HS_ALE: begin
        if (q.cnt == 4'h0) begin
          // device takes the address on this fall
          d.st = bdr_pkg::HS_ADDR;
          d.ale = 1'b0;
        end else begin
          d.cnt = q.cnt - 4'h1;
        end
      end
      bdr_pkg::HS_ADDR: begin
        d.st = bdr_pkg::HS_STRB;
        d.cnt = 4'(bdr_pkg::STRB_CYC - 1);
        d.rd_n = q.wr;
        d.wr_n = !q.wr;
        d.oe = q.wr;
      end
      bdr_pkg::HS_STRB: begin
        if (q.cnt == 4'h0) begin
          d.st = bdr_pkg::HS_END;
          if (!q.wr) begin
            d.rdata = bus.ad;
          end
          d.rd_n = 1'b1;
          d.wr_n = 1'b1;
        end else begin
          d.cnt = q.cnt - 4'h1;
        end
      end
      bdr_pkg::HS_END: begin
        // data held one cycle past the strobe edge
        d.st = bdr_pkg::HS_IDLE;
        d.oe = 1'b0;
      end
      default: begin
        d.st = bdr_pkg::HS_IDLE;
      end
    endcase
    // a second order while busy is dropped
    if (q.dph && q.dwr && !busy) begin
      if (q.daddr == bdr_pkg::HR_ADDR) begin
        d.addr = hwdata[15:0];
      end
      if (q.daddr == bdr_pkg::HR_WDATA) begin
        d.wdata = hwdata[7:0];
      end
    end
  end
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      q <= '{st: bdr_pkg::HS_IDLE, rd_n: 1'b1, wr_n: 1'b1, default: '0};
    end else begin
      q <= d;
    end
  end
  always_comb begin
    case (q.daddr)
      bdr_pkg::HR_ADDR: hrdata = {16'h0000, q.addr};
      bdr_pkg::HR_WDATA: hrdata = {24'h000000, q.wdata};
      bdr_pkg::HR_STAT: hrdata = {16'h0000, q.rdata, 7'h00, busy};
      default: hrdata = 32'h00000000;
    endcase
  end
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign bus.ale = q.ale;
  assign bus.rd_n = q.rd_n;
  assign bus.wr_n = q.wr_n;
  assign bus.addr_hi = q.addr[15:8];
  // address must still stand in the ale-low cycle, where the glue latches it
  assign bus.ad_host = (q.st == bdr_pkg::HS_ALE || q.st == bdr_pkg::HS_ADDR)
    ? q.addr[7:0] : q.wdata;
  assign bus.ad_host_oe = q.oe;
endmodule

// ### hdl/bdr_pin_sync.sv
// three-stage pin synchroniser, output moves when stages two and three agree
`timescale 1ns/1ps
module bdr_pin_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] level_out
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] lvl;
  } bdr_sync_t;
  bdr_sync_t st_q, st_d;
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_comb begin
        st_d.s1[i] = pin_in[i];
        st_d.s2[i] = st_q.s1[i];
        st_d.s3[i] = st_q.s2[i];
        st_d.lvl[i] = (st_q.s2[i] == st_q.s3[i]) ? st_q.s3[i] : st_q.lvl[i];
      end
    end
  endgenerate
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      st_q <= '{s1: INIT, s2: INIT, s3: INIT, lvl: INIT};
    end else begin
      st_q <= st_d;
    end
  end
  assign level_out = st_q.lvl;
endmodule

// ### hdl/bdr_pkg.sv
// shared constants for the board decode and boot remap ends
package bdr_pkg;
  localparam int CLK_HZ = 100_000_000;
  localparam int CLK_NS = 10;
  // address nibbles on a15..a12
  localparam logic [3:0] NIB_CTRL = 4'ha;
  localparam logic [3:0] NIB_PIO = 4'hb;
  localparam logic [3:0] NIB_BP_LO = 4'hc;
  localparam logic [3:0] NIB_BP_HI = 4'hd;
  localparam logic [3:0] NIB_MON_LO = 4'he;
  localparam logic [3:0] NIB_MON_HI = 4'hf;
  localparam logic [2:0] USR0_TOP3 = 3'h0;
  // parallel i/o operations on a2..a0
  localparam logic [2:0] PIO_CMD = 3'h0;
  localparam logic [2:0] PIO_PA = 3'h1;
  localparam logic [2:0] PIO_PB = 3'h2;
  localparam logic [2:0] PIO_PC = 3'h3;
  localparam logic [2:0] PIO_TLO = 3'h4;
  localparam logic [2:0] PIO_THI = 3'h5;
  // command bits
  localparam int CMD_PA_OUT = 0;
  localparam int CMD_PB_OUT = 1;
  localparam int CMD_PC_OUT = 2;
  localparam int CMD_PC_STAT = 3;
  localparam logic [3:0] CMD_RST = 4'h0;
  // timer: half period of the baud square wave in system ticks
  localparam int SYS_HZ = 2_000_000;
  localparam int BAUD_DEF = 2400;
  localparam int DIV_RATIO = 3;
  localparam logic [13:0] TDIV_RST = 14'(SYS_HZ / BAUD_DEF / 2);
  // board reset pulse
  localparam int RST_PULSE_NS = 1000;
  localparam int RST_CYC = (RST_PULSE_NS + CLK_NS - 1) / CLK_NS;
  // host bus timing
  localparam int ALE_NS = 40;
  localparam int STRB_NS = 60;
  localparam int ALE_CYC = (ALE_NS + CLK_NS - 1) / CLK_NS;
  localparam int STRB_CYC = (STRB_NS + CLK_NS - 1) / CLK_NS;
  // host command registers (ahb byte addresses)
  localparam logic [3:0] HR_ADDR = 4'h0;
  localparam logic [3:0] HR_WDATA = 4'h4;
  localparam logic [3:0] HR_CTRL = 4'h8;
  localparam logic [3:0] HR_STAT = 4'hc;
  localparam int HC_GO = 0;
  localparam int HC_WRITE = 1;
  typedef enum logic [2:0] {
    HS_IDLE = 3'h0,
    HS_ALE = 3'h1,
    HS_ADDR = 3'h2,
    HS_STRB = 3'h3,
    HS_END = 3'h4
  } bdr_hstate_t;
endpackage

// ### verification/bdr_monitor.sv
// assertions on the host bus and the board glue outputs
`timescale 1ns/1ps
module bdr_monitor (
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  input wire logic ale,
  input wire logic wr_n,
  input wire logic [7:0] addr_hi,
  input wire logic [7:0] ad,
  input wire logic monitor_low_select_n_out,
  input wire logic monitor_high_select_n_out,
  input wire logic pio_select_n_out,
  input wire logic peripheral_ctrl_select_n_out,
  input wire logic user_low_select_n_out,
  input wire logic [11:0] monitor_byte_addr_out,
  input wire logic io_memory_select_out,
  input wire logic [2:0] pio_op_out,
  input wire logic breakpoint_mem_write_n_out,
  input wire logic boot_remap_latch_n_out,
  input wire logic board_reset_out,
  input wire logic board_reset_n_out
);
  logic [7:0] hi_cnt_q;
  logic [7:0] hi_cnt_d;
  logic [3:0] nib;
  assign nib = addr_hi[7:4];
  always_comb begin
    hi_cnt_d = board_reset_out ? hi_cnt_q + 8'h01 : 8'h00;
  end
  always_ff @(posedge core_clk_in) begin
    hi_cnt_q <= reset_n_in ? hi_cnt_d : 8'h00;
  end
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!reset_n_in);
  // selects settle a cycle after the latch; one more for margin
  sequence addr_latched;
    $fell(ale) ##2 1'b1;
  endsequence
  sequence bp_strobe;
    $fell(wr_n) && !ale && nib[3:1] == 3'h6;
  endsequence
  sel_onehot_a: assert property (
    $countones({~monitor_low_select_n_out, ~monitor_high_select_n_out,
    ~pio_select_n_out, ~peripheral_ctrl_select_n_out,
    ~user_low_select_n_out}) <= 1) else $error("two selects low");
  mon_decode_a: assert property (
    addr_latched |-> monitor_high_select_n_out == (nib != 4'hf) &&
    monitor_low_select_n_out ==
    !(nib == 4'he || (!boot_remap_latch_n_out && nib[3:1] == 3'h0)))
    else $error("monitor select wrong");
  pio_decode_a: assert property (
    addr_latched |-> pio_select_n_out == (nib != 4'hb))
    else $error("pio select wrong");
  ctrl_decode_a: assert property (
    addr_latched |-> peripheral_ctrl_select_n_out == (nib != 4'ha))
    else $error("controller select wrong");
  user_block_a: assert property (
    addr_latched |-> user_low_select_n_out ==
    !(boot_remap_latch_n_out && nib[3:1] == 3'h0))
    else $error("user low select wrong");
  byte_addr_a: assert property (
    addr_latched |-> monitor_byte_addr_out == {addr_hi[3:0], $past(ad, 2)}
    && io_memory_select_out == addr_hi[3] && pio_op_out == $past(ad[2:0], 2))
    else $error("latched low address wrong");
  bp_release_a: assert property (
    bp_strobe |=> !breakpoint_mem_write_n_out ##1 boot_remap_latch_n_out)
    else $error("remap not released");
  reset_hold_a: assert property (
    $rose(reset_n_in) |-> (board_reset_out && !board_reset_n_out &&
    !boot_remap_latch_n_out) [*8]) else $error("reset pulse missing");
  pulse_len_a: assert property (
    $fell(board_reset_out) |-> hi_cnt_q inside {[8'h63:8'h65]})
    else $error("reset pulse length wrong");
endmodule

// ### verification/tb.sv
// bench: ahb master, host end and board glue end back to back
`timescale 1ns/1ps
module tb;
  logic core_clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic osc = 1'b0;
  logic hsel, hwrite, hreadyout, hresp, key_a_n, key_b_n, taken, load;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata;
  logic [7:0] port_a_in, port_b_in, ctrl_out_data, port_a_out;
  logic [7:0] port_a_oe_out, port_b_oe_out, ctrl_in_data_out, port_b_out;
  logic [5:0] port_c_in, port_c_oe_out, port_c_out;
  logic ctrl_clock_6mhz_n_out;
  logic monitor_low_select_n_out, monitor_high_select_n_out;
  logic pio_select_n_out, peripheral_ctrl_select_n_out;
  logic user_low_select_n_out, io_memory_select_out;
  logic [11:0] monitor_byte_addr_out;
  logic [2:0] pio_op_out;
  logic breakpoint_mem_write_n_out, boot_remap_latch_n_out;
  logic board_reset_out, board_reset_n_out, ctrl_clock_6mhz_out;
  logic divided_system_clock_out, serial_rate_clock_out;
  logic ctrl_in_is_cmd_out, ctrl_in_full_out, ctrl_out_full_out;
  logic [4:0] sel_seen;
  logic remap_m;
  int n_fail = 0;
  int n_compared = 0;
  int ram_m [256];
  int aq [$];
  bdr_bus_if bus();
  always #5 core_clk_in = ~core_clk_in;
  // near 6 mhz, not locked to the core clock
  always #83 osc = ~osc;
  always @(posedge core_clk_in) begin
    if (!bus.rd_n || !bus.wr_n) begin
      sel_seen <= {monitor_low_select_n_out, monitor_high_select_n_out,
        pio_select_n_out, peripheral_ctrl_select_n_out, user_low_select_n_out};
    end
  end
  bdr_host_end bdr_host_end_i (.core_clk_in, .reset_n_in, .hsel, .haddr,
    .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata,
    .hreadyout, .hresp, .bus);
  bdr_glue_end bdr_glue_end_i (.core_clk_in, .reset_n_in, .bus,
    .key_a_n_in(key_a_n), .key_b_n_in(key_b_n), .osc_6mhz_in(osc),
    .monitor_low_select_n_out, .monitor_high_select_n_out, .pio_select_n_out,
    .peripheral_ctrl_select_n_out, .user_low_select_n_out,
    .monitor_byte_addr_out, .io_memory_select_out, .pio_op_out,
    .breakpoint_mem_write_n_out, .boot_remap_latch_n_out, .board_reset_out,
    .board_reset_n_out, .ctrl_clock_6mhz_out, .ctrl_clock_6mhz_n_out,
    .divided_system_clock_out, .serial_rate_clock_out, .port_a_in,
    .port_a_out, .port_a_oe_out, .port_b_in, .port_b_out, .port_b_oe_out,
    .port_c_in, .port_c_out, .port_c_oe_out, .ctrl_in_data_out,
    .ctrl_in_is_cmd_out, .ctrl_in_full_out, .ctrl_in_taken_in(taken),
    .ctrl_out_data_in(ctrl_out_data), .ctrl_out_load_in(load),
    .ctrl_out_full_out);
  bdr_monitor bdr_monitor_i (.core_clk_in, .reset_n_in, .ale(bus.ale),
    .wr_n(bus.wr_n), .addr_hi(bus.addr_hi), .ad(bus.ad),
    .monitor_low_select_n_out, .monitor_high_select_n_out, .pio_select_n_out,
    .peripheral_ctrl_select_n_out, .user_low_select_n_out,
    .monitor_byte_addr_out, .io_memory_select_out, .pio_op_out,
    .breakpoint_mem_write_n_out, .boot_remap_latch_n_out, .board_reset_out,
    .board_reset_n_out);
  task automatic finish_test();
    $display("counts: %0d compared, %0d failed", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic tmo();
    n_fail++;
    finish_test();
  endtask
  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      n_fail++;
      $display("Error at %0t: expected %h got %h", $time, e, g);
    end
  endtask
  task automatic chk_sel(input logic [15:0] a);
    logic [4:0] e;
    e = 5'h1f;
    e[4] = !(a[15:12] == 4'he || (!remap_m && a[15:13] == 3'h0));
    e[3] = a[15:12] != 4'hf;
    e[2] = a[15:12] != 4'hb;
    e[1] = a[15:12] != 4'ha;
    e[0] = !(remap_m && a[15:13] == 3'h0);
    chk({27'h0, e}, {27'h0, sel_seen});
  endtask
  task automatic edge_ready();
    int k;
    for (k = 0; k == 0 || (hreadyout !== 1'b1 && k < 100); k++) begin
      @(posedge core_clk_in);
    end
    if (k >= 100) tmo();
  endtask
  task automatic ahb(input logic w, input logic [3:0] a,
      input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {28'h0, a};
    hwrite <= w;
    edge_ready();
    htrans <= 2'b00;
    hwdata <= d;
    edge_ready();
    r = hrdata;
  endtask
  // one host bus cycle, then poll busy; returns the byte read
  task automatic op(input logic w, input logic [15:0] a,
      input logic [7:0] d, output logic [7:0] r);
    logic [31:0] x;
    int k;
    ahb(1'b1, 4'h0, {16'h0, a}, x);
    ahb(1'b1, 4'h4, {24'h0, d}, x);
    ahb(1'b1, 4'h8, {30'h0, w, 1'b1}, x);
    ahb(1'b0, 4'hc, 32'h0, x);
    ahb(1'b0, 4'hc, 32'h0, x);
    for (k = 0; k < 50 && x[0] !== 1'b0; k++) begin
      ahb(1'b0, 4'hc, 32'h0, x);
    end
    if (k >= 50) tmo();
    r = x[15:8];
  endtask
  task automatic brst_wait();
    int k;
    @(posedge core_clk_in);
    for (k = 0; k < 300 && board_reset_out !== 1'b0; k++) begin
      @(posedge core_clk_in);
    end
    if (k >= 300) tmo();
  endtask
  // counts slow-clock edges between baud toggles
  task automatic clocks();
    logic pc, pd, pb;
    int no, nd, nb, k;
    pc = ctrl_clock_6mhz_out;
    pd = divided_system_clock_out;
    pb = serial_rate_clock_out;
    no = 0;
    nd = 0;
    nb = 0;
    for (k = 0; k < 60000 && nb < 2; k++) begin
      @(posedge core_clk_in);
      if (ctrl_clock_6mhz_out && !pc) no++;
      if (divided_system_clock_out && !pd) begin
        if (nb == 1) nd++;
        if (nd == 2) chk(32'h3, 32'(no));
        no = 0;
      end
      if (serial_rate_clock_out !== pb) nb++;
      pc = ctrl_clock_6mhz_out;
      pd = divided_system_clock_out;
      pb = serial_rate_clock_out;
    end
    if (k >= 60000) tmo();
    chk(32'(bdr_pkg::TDIV_RST) + 32'h1, 32'(nd));
    chk(32'h1, {31'h0, ctrl_clock_6mhz_out ^ ctrl_clock_6mhz_n_out});
  endtask
  initial begin
    logic [7:0] r;
    logic [7:0] d;
    logic [15:0] tbl [6];
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    key_a_n = 1'b1;
    key_b_n = 1'b1;
    taken = 1'b0;
    load = 1'b0;
    ctrl_out_data = 8'h00;
    void'($urandom(64522));
    port_a_in = 8'($urandom);
    port_b_in = 8'($urandom);
    port_c_in = 6'($urandom);
    tbl = '{16'h0000, 16'h1fff, 16'he000, 16'hf0ff, 16'hb800, 16'ha001};
    repeat (20) @(posedge core_clk_in);
    reset_n_in <= 1'b1;
    @(posedge core_clk_in);
    #1;
    chk(32'h1, {31'h0, board_reset_out});
    chk(32'h0, {31'h0, boot_remap_latch_n_out});
    chk(32'h0, {8'h0, port_a_oe_out, port_b_oe_out, 2'h0, port_c_oe_out});
    remap_m = 1'b0;
    brst_wait();
    for (int p = 0; p < 2; p++) begin
      foreach (tbl[i]) begin
        op(1'b0, tbl[i], 8'h00, r);
        chk_sel(tbl[i]);
      end
      op(1'b1, 16'hc000, 8'h00, r);
      remap_m = 1'b1;
      chk(32'h1, {31'h0, boot_remap_latch_n_out});
    end
    $display("test decode done");
    op(1'b0, 16'hb802, 8'h00, r);
    chk({24'h0, port_b_in}, {24'h0, r});
    op(1'b0, 16'hb803, 8'h00, r);
    chk({26'h0, port_c_in}, {26'h0, r[5:0]});
    repeat (4) begin
      aq.push_back($urandom_range(255));
      ram_m[aq[$]] = $urandom_range(255);
      op(1'b1, 16'(16'hb000 + aq[$]), 8'(ram_m[aq[$]]), r);
    end
    foreach (aq[i]) begin
      op(1'b0, 16'(16'hb000 + aq[i]), 8'h00, r);
      chk(32'(ram_m[aq[i]]), {24'h0, r});
    end
    op(1'b0, 16'hb804, 8'h00, r);
    op(1'b0, 16'hb805, 8'h00, d);
    chk({18'h0, bdr_pkg::TDIV_RST}, {16'h0, d, r});
    op(1'b1, 16'hb800, 8'h07, r);
    chk(32'h00ffff3f,
      {8'h0, port_a_oe_out, port_b_oe_out, 2'h0, port_c_oe_out});
    d = 8'($urandom);
    op(1'b1, 16'hb801, d, r);
    chk({24'h0, d}, {24'h0, port_a_out});
    op(1'b1, 16'hb802, d, r);
    chk({24'h0, d}, {24'h0, port_b_out});
    op(1'b1, 16'hb803, d, r);
    chk({26'h0, d[5:0]}, {26'h0, port_c_out});
    op(1'b1, 16'hb800, 8'h0b, r);
    op(1'b0, 16'hb803, 8'h00, r);
    chk(32'h03, {24'h0, r});
    chk(32'h0, {26'h0, port_c_oe_out});
    $display("test pio done");
    op(1'b1, 16'ha001, d, r);
    chk({22'h0, d, 2'b01}, {22'h0, ctrl_in_data_out,
      ctrl_in_is_cmd_out, ctrl_in_full_out});
    op(1'b0, 16'ha000, 8'h00, r);
    chk(32'h02, {24'h0, r});
    taken <= 1'b1;
    @(posedge core_clk_in);
    taken <= 1'b0;
    @(posedge core_clk_in);
    chk(32'h0, {31'h0, ctrl_in_full_out});
    op(1'b1, 16'ha000, 8'h5a, r);
    chk({22'h0, 8'h5a, 2'b11}, {22'h0, ctrl_in_data_out,
      ctrl_in_is_cmd_out, ctrl_in_full_out});
    d = 8'($urandom);
    ctrl_out_data <= d;
    load <= 1'b1;
    @(posedge core_clk_in);
    load <= 1'b0;
    op(1'b0, 16'ha000, 8'h00, r);
    chk(32'h0b, {24'h0, r});
    chk(32'h1, {31'h0, ctrl_out_full_out});
    op(1'b0, 16'ha001, 8'h00, r);
    chk({24'h0, d}, {24'h0, r});
    op(1'b0, 16'ha000, 8'h00, r);
    chk(32'h0a, {24'h0, r});
    chk(32'h0, {31'h0, ctrl_out_full_out});
    $display("test controller done");
    clocks();
    $display("test clocks done");
    key_a_n <= 1'b0;
    repeat (20) @(posedge core_clk_in);
    chk(32'h0, {31'h0, board_reset_out});
    key_a_n <= 1'b1;
    repeat (5) @(posedge core_clk_in);
    key_a_n <= 1'b0;
    key_b_n <= 1'b0;
    repeat (10) @(posedge core_clk_in);
    chk(32'h1, {31'h0, board_reset_out});
    chk(32'h0, {31'h0, boot_remap_latch_n_out});
    key_a_n <= 1'b1;
    key_b_n <= 1'b1;
    remap_m = 1'b0;
    brst_wait();
    op(1'b0, 16'h0000, 8'h00, r);
    chk_sel(16'h0000);
    $display("test keys done");
    finish_test();
  end
endmodule
